// ### hdl/slsl_line_status.sv
// line status logic: receiver framing checks, flags and the status register
`timescale 1ns/100ps
`default_nettype none
module slsl_line_status
#(
   parameter int DIV   = slsl_pkg::DIV_DEFAULT,
   parameter int DEPTH = slsl_pkg::RX_DEPTH
)
(
   // clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_nrst,
   // host register port
   input  wire logic [2:0] i_addr,
   input  wire logic       i_rd,
   input  wire logic       i_wr,
   output logic [7:0]      o_rdata,
   // configuration
   input  wire logic       i_fifo_mode,
   input  wire logic       i_parity_enable,
   input  wire logic       i_parity_even_select,
   input  wire logic [1:0] i_word_len_sel,
   input  wire logic       i_hold_empty_irq_en,
   input  wire logic       i_line_irq_en,
   // transmit path status
   input  wire logic       i_tx_hold_write,
   input  wire logic       i_tx_hold_to_shift,
   input  wire logic       i_tx_queue_empty,
   input  wire logic       i_tx_shift_busy,
   // serial line
   input  wire logic       i_serial_receive_input,
   // interrupt requests
   output logic            o_hold_empty_irq,
   output logic            o_line_irq
);
   import slsl_pkg::*;

   typedef struct packed
   {
      slsl_rx_state_e st;
      logic [3:0]     ticks;
      logic [3:0]     bitn;
      logic [7:0]     shreg;
      logic           par_bad;
      logic           all_zero;
      logic           resync;
      logic [7:0]     hold_data;
      logic           data_ready;
      logic           overrun;
      logic           parity_err;
      logic           framing_err;
      logic           brk;
      logic           hold_empty;
      logic           queue_err_latched;
      logic           head_ack;
      logic [7:0]     rdata;
   } slsl_state_s;

   slsl_state_s st_q;
   slsl_state_s st_d;

   logic                  tick;
   logic                  rd_status;
   logic                  rd_data;
   logic                  done;
   logic                  done_brk;
   logic                  done_frm;
   logic                  done_par;
   logic [RX_ENTRY_W-1:0] entry;
   logic [RX_ENTRY_W-1:0] head;
   logic                  f_empty;
   logic                  f_full;
   logic                  f_any_err;
   logic                  push;
   logic                  all_empty;
   logic [7:0]            status;
   logic [3:0]            data_bits;
   logic                  rx_in;

   // ========================================================================
   // oversample enable and receive storage
   slsl_tick_div #(.DIV(DIV)) u_div
   (
      .i_clock (i_clock),
      .i_nrst  (i_nrst),
      .o_tick  (tick)
   );

   slsl_rx_fifo #(.W(RX_ENTRY_W), .DEPTH(DEPTH)) u_fifo
   (
      .i_clock     (i_clock),
      .i_nrst      (i_nrst),
      .i_flush     (!i_fifo_mode),
      .i_push      (push),
      .i_wdata     (entry),
      .i_pop       (rd_data && i_fifo_mode),
      .o_head      (head),
      .o_empty     (f_empty),
      .o_full      (f_full),
      .o_any_error (f_any_err)
   );

   // ========================================================================
   // decode and helpers
   function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs, input logic s);
      hit = s && (a == ofs);
   endfunction : hit

   assign rd_status = hit(i_addr, LINE_STATUS_OFS, i_rd);
   assign rd_data   = hit(i_addr, RX_DATA_OFS, i_rd);
   assign data_bits = 4'h5 + {2'b00, i_word_len_sel};
   assign rx_in     = i_serial_receive_input;
   assign done_brk  = st_q.all_zero && !rx_in;
   assign done_frm  = !rx_in;
   assign done_par  = st_q.par_bad;
   assign entry     = {done_brk, done_frm && !done_brk, done_par && !done_brk,
                       done_brk ? 8'h00 : st_q.shreg};
   assign done      = tick && (st_q.st == SLSL_STOP) && (st_q.ticks == FULL_BIT_TICKS);
   assign push      = done && i_fifo_mode;
   // transmit side: fifo mode uses the transmit queue in place of the holding register
   assign all_empty = (i_fifo_mode ? i_tx_queue_empty : st_q.hold_empty) && !i_tx_shift_busy;

   // ========================================================================
   // status word: fifo mode reports errors of the head character
   always_comb
   begin
      status = 8'h00;
      if (i_fifo_mode)
      begin
         status[BIT_DATA_READY]  = !f_empty;
         status[BIT_PARITY_ERR]  = !f_empty && !st_q.head_ack && head[ENT_PAR];
         status[BIT_FRAMING_ERR] = !f_empty && !st_q.head_ack && head[ENT_FRM];
         status[BIT_BREAK]       = !f_empty && !st_q.head_ack && head[ENT_BRK];
         status[BIT_QUEUE_ERROR] = st_q.queue_err_latched;
      end
      else
      begin
         status[BIT_DATA_READY]  = st_q.data_ready;
         status[BIT_PARITY_ERR]  = st_q.parity_err;
         status[BIT_FRAMING_ERR] = st_q.framing_err;
         status[BIT_BREAK]       = st_q.brk;
      end
      status[BIT_OVERRUN]    = st_q.overrun;
      status[BIT_HOLD_EMPTY] = st_q.hold_empty;
      status[BIT_ALL_EMPTY]  = all_empty;
   end

   // ========================================================================
   // receiver sequencing and flag updates
   always_comb
   begin
      st_d = st_q;
      if (tick)
      begin
         st_d.ticks = st_q.ticks + 4'h1;
         case (st_q.st)
            SLSL_IDLE:
            begin
               st_d.ticks = 4'h0;
               if (!rx_in)
                  st_d.st = SLSL_START;
            end
            SLSL_START:
            begin
               // mid-bit check rejects glitches; a resync start is sampled a second time here
               if (st_q.ticks == HALF_BIT_TICKS)
               begin
                  st_d.ticks    = 4'h0;
                  st_d.bitn     = 4'h0;
                  st_d.par_bad  = 1'b0;
                  st_d.all_zero = 1'b1;
                  st_d.resync   = 1'b0;
                  st_d.st       = rx_in ? SLSL_IDLE : SLSL_DATA;
               end
            end
            SLSL_DATA:
            begin
               if (st_q.ticks == FULL_BIT_TICKS)
               begin
                  st_d.shreg    = {rx_in, st_q.shreg[7:1]};
                  st_d.par_bad  = st_q.par_bad ^ rx_in;
                  st_d.all_zero = st_q.all_zero && !rx_in;
                  st_d.bitn     = st_q.bitn + 4'h1;
                  if (st_q.bitn == data_bits - 4'h1)
                  begin
                     st_d.st = i_parity_enable ? SLSL_PAR : SLSL_STOP;
                     // short words land right-aligned
                     st_d.shreg = {rx_in, st_q.shreg[7:1]} >> (4'h8 - data_bits);
                  end
               end
            end
            SLSL_PAR:
            begin
               if (st_q.ticks == FULL_BIT_TICKS)
               begin
                  // even parity wants an even count of ones over data and parity
                  st_d.par_bad  = (st_q.par_bad ^ rx_in) ^ !i_parity_even_select;
                  st_d.all_zero = st_q.all_zero && !rx_in;
                  st_d.st       = SLSL_STOP;
               end
            end
            SLSL_STOP:
            begin
               if (st_q.ticks == FULL_BIT_TICKS)
               begin
                  st_d.ticks = 4'h0;
                  if (done_brk)
                     st_d.st = SLSL_BRK_WAIT;
                  else if (done_frm)
                     st_d.st = SLSL_START;
                  else
                     st_d.st = SLSL_IDLE;
               end
            end
            SLSL_BRK_WAIT:
            begin
               // line must idle high half a bit before a new start is accepted
               if (!rx_in)
                  st_d.ticks = 4'h0;
               else if (st_q.ticks == HALF_BIT_TICKS)
                  st_d.st = SLSL_IDLE;
            end
            default:
               st_d.st = SLSL_IDLE;
         endcase
         if (!i_parity_enable)
            st_d.par_bad = 1'b0;
      end

      // clears from host reads first, so a completing character wins below
      if (rd_status)
      begin
         st_d.overrun     = 1'b0;
         st_d.parity_err  = 1'b0;
         st_d.framing_err = 1'b0;
         st_d.brk         = 1'b0;
         st_d.queue_err_latched = 1'b0;
      end
      if (rd_data && !i_fifo_mode)
         st_d.data_ready = 1'b0;
      if (rd_data)
         st_d.rdata = !i_fifo_mode ? st_q.hold_data : (f_empty ? 8'h00 : head[7:0]);
      else if (rd_status)
         st_d.rdata = status;

      // a status read hides the head's error marks until the next character reaches the head
      if (rd_data || f_empty)
         st_d.head_ack = 1'b0;
      if (rd_status && i_fifo_mode && !f_empty)
         st_d.head_ack = 1'b1;

      // queue error summary latches while the stored error count is nonzero and clears on a status read, set wins over a read
      if (f_any_err && !rd_status)
         st_d.queue_err_latched = 1'b1;
      else if (f_any_err && rd_status)
         st_d.queue_err_latched = 1'b1;
      if (!i_fifo_mode)
         st_d.queue_err_latched = 1'b0;

      if (done)
      begin
         if (i_fifo_mode)
         begin
            if (f_full && !(rd_data))
               st_d.overrun = 1'b1;
         end
         else
         begin
            if (st_q.data_ready && !rd_data)
               st_d.overrun = 1'b1;
            st_d.hold_data   = entry[7:0];
            st_d.data_ready  = 1'b1;
            st_d.parity_err  = st_q.parity_err | entry[ENT_PAR];
            st_d.framing_err = st_q.framing_err | entry[ENT_FRM];
            st_d.brk         = st_q.brk | entry[ENT_BRK];
         end
      end

      // holding-empty: the move into the shift register or an emptied queue sets it
      if (i_tx_hold_write)
         st_d.hold_empty = 1'b0;
      if (i_fifo_mode ? i_tx_queue_empty && !i_tx_hold_write : i_tx_hold_to_shift)
         st_d.hold_empty = 1'b1;
   end

   // ========================================================================
   // state register; writes to the status word are ignored on purpose
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         st_q            <= '0;
         st_q.st         <= SLSL_IDLE;
         st_q.hold_empty <= LINE_STATUS_RST[BIT_HOLD_EMPTY];
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // ========================================================================
   // outputs
   assign o_rdata          = st_q.rdata;
   assign o_hold_empty_irq = i_hold_empty_irq_en && st_q.hold_empty;
   assign o_line_irq       = i_line_irq_en && (|status[BIT_BREAK:BIT_OVERRUN]);
endmodule : slsl_line_status
`default_nettype wire

// ### shared/slsl_pkg.sv
// package of constants and types for the serial line status logic
`default_nettype none
package slsl_pkg;
   // ========================================================================
   // register map
   localparam logic [2:0] LINE_STATUS_OFS = 3'h5;
   localparam logic [2:0] RX_DATA_OFS     = 3'h0;
   localparam logic [7:0] LINE_STATUS_RST = 8'h60;
   // ========================================================================
   // line status bit positions
   localparam int BIT_DATA_READY   = 0;
   localparam int BIT_OVERRUN      = 1;
   localparam int BIT_PARITY_ERR   = 2;
   localparam int BIT_FRAMING_ERR  = 3;
   localparam int BIT_BREAK        = 4;
   localparam int BIT_HOLD_EMPTY   = 5;
   localparam int BIT_ALL_EMPTY    = 6;
   localparam int BIT_QUEUE_ERROR  = 7;
   // ========================================================================
   // receive FIFO geometry and entry layout: {break, framing, parity, data}
   localparam int RX_DEPTH         = 16;
   localparam int RX_ENTRY_W       = 11;
   localparam int ENT_PAR          = 8;
   localparam int ENT_FRM          = 9;
   localparam int ENT_BRK          = 10;
   // ========================================================================
   // timing: clock and bit rates
   localparam int CLOCK_HZ         = 25_000_000;
   localparam int OVERSAMPLE       = 16;
   localparam int BAUD_DEFAULT     = 9600;
   localparam int DIV_DEFAULT      = CLOCK_HZ / (BAUD_DEFAULT * OVERSAMPLE);
   localparam logic [3:0] HALF_BIT_TICKS = 4'h7;
   localparam logic [3:0] FULL_BIT_TICKS = 4'hF;
   // ========================================================================
   // receiver states
   typedef enum logic [2:0] {SLSL_IDLE, SLSL_START, SLSL_DATA, SLSL_PAR, SLSL_STOP, SLSL_BRK_WAIT}
      slsl_rx_state_e;
endpackage : slsl_pkg
`default_nettype wire

// ### hdl/slsl_tick_div.sv
// divider giving the one-cycle oversample enable
`timescale 1ns/100ps
`default_nettype none
module slsl_tick_div
#(
   parameter int DIV = slsl_pkg::DIV_DEFAULT
)
(
   // clock and reset
   input  wire logic i_clock,
   input  wire logic i_nrst,
   // enable out
   output logic      o_tick
);
   import slsl_pkg::*;

   typedef struct packed
   {
      logic [15:0] cnt;
      logic        tick;
   } slsl_div_s;

   slsl_div_s st_q;
   slsl_div_s st_d;

   // ========================================================================
   // counter wraps at DIV-1 and pulses the enable for one cycle
   always_comb
   begin
      st_d      = st_q;
      st_d.tick = 1'b0;
      if (st_q.cnt == 16'(DIV - 1))
      begin
         st_d.cnt  = 16'h0000;
         st_d.tick = 1'b1;
      end
      else
      begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   assign o_tick = st_q.tick;
endmodule : slsl_tick_div
`default_nettype wire

// ### hdl/slsl_rx_fifo.sv
// receive FIFO holding each character with its error bits
`timescale 1ns/100ps
`default_nettype none
module slsl_rx_fifo
#(
   parameter int W     = slsl_pkg::RX_ENTRY_W,
   parameter int DEPTH = slsl_pkg::RX_DEPTH
)
(
   // clock and reset
   input  wire logic         i_clock,
   input  wire logic         i_nrst,
   input  wire logic         i_flush,
   // write side
   input  wire logic         i_push,
   input  wire logic [W-1:0] i_wdata,
   // read side
   input  wire logic         i_pop,
   output logic [W-1:0]      o_head,
   output logic              o_empty,
   output logic              o_full,
   // set while any stored entry carries an error
   output logic              o_any_error
);
   import slsl_pkg::*;
   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic [AW:0]   errs;
   } slsl_fifo_s;

   slsl_fifo_s         st_q;
   slsl_fifo_s         st_d;
   logic [W-1:0]       mem [DEPTH];
   logic               do_push;
   logic               do_pop;
   logic               in_err;
   logic               out_err;

   // ========================================================================
   // pointers, fill level and error count move together
   always_comb
   begin
      do_pop  = i_pop && (st_q.cnt != '0);
      // a pop frees the slot that a push in the same cycle takes
      do_push = i_push && ((st_q.cnt != (AW+1)'(DEPTH)) || do_pop);
      in_err  = |i_wdata[ENT_BRK:ENT_PAR];
      out_err = |mem[st_q.rp][ENT_BRK:ENT_PAR];
      st_d    = st_q;
      if (do_push)
         st_d.wp = st_q.wp + AW'(1);
      if (do_pop)
         st_d.rp = st_q.rp + AW'(1);
      st_d.cnt  = st_q.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
      st_d.errs = st_q.errs + (AW+1)'(do_push && in_err) - (AW+1)'(do_pop && out_err);
      if (i_flush)
         st_d = '0;
   end

   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge i_clock)
   begin
      if (do_push)
         mem[st_q.wp] <= i_wdata;
   end

   assign o_head      = mem[st_q.rp];
   assign o_empty     = (st_q.cnt == '0);
   assign o_full      = (st_q.cnt == (AW+1)'(DEPTH));
   assign o_any_error = (st_q.errs != '0);
endmodule : slsl_rx_fifo
`default_nettype wire

// ### tb/slsl_line_status_checker.sv
// port checker for the serial line status block
`timescale 1ns/100ps
`default_nettype none
module slsl_line_status_checker
   import slsl_pkg::*;
#(
   parameter int DIV   = 1,
   parameter int DEPTH = 16
)
(
   // clock and reset
   input wire logic       i_clock,
   input wire logic       i_nrst,
   // host side
   input wire logic [2:0] i_addr,
   input wire logic       i_rd,
   input wire logic       i_wr,
   input wire logic [7:0] o_rdata,
   // configuration, transmit status and serial line
   input wire logic       i_fifo_mode,
   input wire logic       i_parity_enable,
   input wire logic       i_parity_even_select,
   input wire logic [1:0] i_word_len_sel,
   input wire logic       i_hold_empty_irq_en,
   input wire logic       i_line_irq_en,
   input wire logic       i_tx_hold_write,
   input wire logic       i_tx_hold_to_shift,
   input wire logic       i_tx_queue_empty,
   input wire logic       i_tx_shift_busy,
   input wire logic       i_serial_receive_input,
   // interrupt requests
   input wire logic       o_hold_empty_irq,
   input wire logic       o_line_irq
);
   // ===========================================================================
   // read strobes as the block samples them
   logic st_rd;
   logic dt_rd;
   assign st_rd = i_rd && (i_addr == LINE_STATUS_OFS);
   assign dt_rd = i_rd && (i_addr == RX_DATA_OFS);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // ===========================================================================
   // assertions; non-fifo only where head flags could be shown live again
   a_hold_irq_gate: assert property (!i_hold_empty_irq_en |-> !o_hold_empty_irq)
      else $error("holding empty interrupt without enable");
   a_line_irq_gate: assert property (!i_line_irq_en |-> !o_line_irq)
      else $error("line interrupt without enable");
   a_rdata_stands: assert property (!i_rd |=> $stable(o_rdata))
      else $error("read data moved without a read");
   a_hold_write_clr: assert property (i_tx_hold_write && !i_tx_hold_to_shift && !i_fifo_mode
      ##1 i_hold_empty_irq_en |-> !o_hold_empty_irq) else $error("holding empty kept after write");
   a_hold_move_set: assert property (i_tx_hold_to_shift && !i_tx_hold_write && !i_fifo_mode
      ##1 i_hold_empty_irq_en |-> o_hold_empty_irq) else $error("no interrupt after move to shift");
   a_busy_not_empty: assert property (st_rd && i_tx_shift_busy |=> !o_rdata[BIT_ALL_EMPTY])
      else $error("all empty shown while shift busy");
   a_queue_not_empty: assert property (st_rd && i_fifo_mode && !i_tx_queue_empty |=> !o_rdata[BIT_ALL_EMPTY])
      else $error("all empty shown with transmit queue filled");
   a_no_fifo_err: assert property (st_rd && !i_fifo_mode |=> !o_rdata[BIT_QUEUE_ERROR])
      else $error("queue error flag outside fifo operation");
   a_read_clears: assert property (st_rd && !i_fifo_mode ##2 st_rd |=> o_rdata[4:1] == 4'h0)
      else $error("error flags survived a status read");
   a_data_read_clr: assert property (dt_rd && !i_fifo_mode ##2 st_rd |=> !o_rdata[BIT_DATA_READY])
      else $error("data ready survived a data read");
   a_line_irq_drop: assert property (st_rd && !i_fifo_mode && i_line_irq_en |=> !o_line_irq)
      else $error("line interrupt kept after status read");
   // ===========================================================================
   // main scenarios seen
   c_break: cover property (st_rd ##1 o_rdata[BIT_BREAK]);
   c_line_irq: cover property (o_line_irq);
   c_queue_err: cover property (st_rd && i_fifo_mode ##1 o_rdata[BIT_QUEUE_ERROR]);
endmodule : slsl_line_status_checker
bind slsl_line_status slsl_line_status_checker #(.DIV(DIV), .DEPTH(DEPTH)) u_slsl_line_status_checker (.*);
`default_nettype wire

// ### tb/slsl_remote_tx.sv
// model of the remote serial transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module slsl_remote_tx
#(
   parameter int BIT_CLKS = 16
)
(
   // clock
   input  wire logic i_clock,
   // receive line of the block, idle at mark
   output logic      o_line
);
   // ===========================================================================
   // line level held for n clocks, changed only just after an edge
   initial o_line = 1'b1;
   task automatic bit_out(input logic b, input int n);
      o_line <= b;
      repeat (n) @(posedge i_clock);
   endtask : bit_out
   // one frame, lsb first; a bad stop is low only around its middle so the resync finds no start
   task automatic send(input logic [7:0] d, input int n, input logic pen, input logic p, input logic fbad);
      @(posedge i_clock);
      bit_out(1'b0, BIT_CLKS);
      for (int i = 0; i < n; i++) bit_out(d[i], BIT_CLKS);
      if (pen) bit_out(p, BIT_CLKS);
      if (fbad) begin bit_out(1'b1, 2); bit_out(1'b0, BIT_CLKS - 4); bit_out(1'b1, 2); end
      else bit_out(1'b1, BIT_CLKS);
   endtask : send
   // spacing for n clocks, then back to mark
   task automatic brk(input int n);
      @(posedge i_clock);
      bit_out(1'b0, n);
      o_line <= 1'b1;
   endtask : brk
endmodule : slsl_remote_tx
`default_nettype wire

// ### tb/slsl_line_status_tb.sv
// self-checking testbench of the serial line status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module slsl_line_status_tb;
   import slsl_pkg::*;
   localparam int DEP = 4;
   logic       i_clock, i_nrst, i_rd, i_wr, i_fifo_mode, i_parity_enable, i_parity_even_select;
   logic       i_hold_empty_irq_en, i_line_irq_en, i_tx_hold_write, i_tx_hold_to_shift;
   logic       i_tx_queue_empty, i_tx_shift_busy, i_serial_receive_input, o_hold_empty_irq, o_line_irq;
   logic [2:0] i_addr;
   logic [1:0] i_word_len_sel;
   logic [7:0] o_rdata;
   // reference model state: sticky flags, holding byte and queue of {brk, frm, par, data}
   int         num_errors = 0, num_checks = 0, dr = 0, flags = 0, q7 = 0, rbr = 0, last = 0, tx_holding_empty = 1, tx_all_empty = 1;
   int         q[$];
   // ===========================================================================
   // design and remote transmitter; a short bit divider keeps the run brief
   slsl_line_status #(.DIV(1), .DEPTH(DEP)) u_slsl_line_status (.i_clock, .i_nrst, .i_addr, .i_rd, .i_wr,
      .o_rdata, .i_fifo_mode, .i_parity_enable, .i_parity_even_select, .i_word_len_sel, .i_hold_empty_irq_en,
      .i_line_irq_en, .i_tx_hold_write, .i_tx_hold_to_shift, .i_tx_queue_empty, .i_tx_shift_busy,
      .i_serial_receive_input, .o_hold_empty_irq, .o_line_irq);
   slsl_remote_tx u_slsl_remote_tx (.i_clock(i_clock), .o_line(i_serial_receive_input));
   // ===========================================================================
   // model helpers
   function automatic int errs(input int c);
      return (c >> 6) & 32'h1C;
   endfunction : errs
   // a completed character as the block should take it
   task automatic arrive(input int c);
      if (!i_fifo_mode) begin
         if (dr) flags |= 2;
         rbr = c & 255;
         dr = 1;
         flags |= errs(c);
      end
      else if (q.size() == DEP) flags |= 2;
      else begin
         if (q.size() == 0) flags |= errs(c);
         if (errs(c) != 0) q7 = 1;
         q.push_back(c);
      end
   endtask : arrive
   // one host read; result taken the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] m);
      int e;
      @(posedge i_clock);
      {i_addr, i_rd} <= {a, 1'b1};
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      if (a == LINE_STATUS_OFS) begin
         e = (q7 << 7) | (tx_all_empty << 6) | (tx_holding_empty << 5) | flags | (i_fifo_mode ? int'(q.size() > 0) : dr);
         flags = 0;
         q7 = 0;
         foreach (q[i]) if (errs(q[i]) != 0) q7 = 1;
      end
      else if (a != RX_DATA_OFS) e = last;
      else if (!i_fifo_mode) begin e = rbr; dr = 0; end
      else begin
         e = q.pop_front() & 255;
         if (q.size() > 0) flags |= errs(q[0]);
      end
      last = e;
      `CHK(o_rdata & m, e[7:0] & m)
   endtask : rd
   // send a character; bad 1 flips parity, bad 2 spoils the stop bit
   task automatic ch(input int d, input int bad);
      int n, p;
      @(posedge i_clock);
      n = 5 + i_word_len_sel;
      d = d & ((1 << n) - 1);
      p = ($countones(d) + !i_parity_even_select + (bad & 1)) & 1;
      u_slsl_remote_tx.send(d[7:0], n, i_parity_enable, p[0], bad[1]);
      repeat (8) @(posedge i_clock);
      arrive(d | ((bad & 1 & i_parity_enable) << 8) | ((bad >> 1) << 9));
   endtask : ch
   // break of twenty bit times, then mark long enough to restart
   task automatic brk_ch();
      u_slsl_remote_tx.brk(320);
      repeat (40) @(posedge i_clock);
      arrive(32'h400);
   endtask : brk_ch
   // write, move to shift (or queue drains), shift drains
   task automatic tx_seq();
      @(posedge i_clock);
      {i_tx_hold_write, i_tx_queue_empty, i_hold_empty_irq_en} <= 3'b101;
      @(posedge i_clock);
      i_tx_hold_write <= 1'b0;
      tx_holding_empty = 0;
      tx_all_empty = 0;
      rd(LINE_STATUS_OFS, 8'hFF);
      `CHK(o_hold_empty_irq, 1'b0)
      @(posedge i_clock);
      {i_tx_hold_to_shift, i_tx_queue_empty, i_tx_shift_busy} <= {!i_fifo_mode, 2'b11};
      @(posedge i_clock);
      i_tx_hold_to_shift <= 1'b0;
      tx_holding_empty = 1;
      rd(LINE_STATUS_OFS, 8'hFF);
      `CHK(o_hold_empty_irq, 1'b1)
      @(posedge i_clock);
      {i_tx_shift_busy, i_hold_empty_irq_en} <= 2'b00;
      tx_all_empty = 1;
      rd(LINE_STATUS_OFS, 8'hFF);
   endtask : tx_seq
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   // ===========================================================================
   // clock and hang guard
   initial
   begin
      i_clock = 1'b0;
      forever #20 i_clock = ~i_clock;
   end
   initial
   begin
      repeat (100000) @(posedge i_clock);
      num_errors++;
      final_report();
   end
   // ===========================================================================
   // main sequence
   initial
   begin : main
      int r;
      {i_rd, i_wr, i_fifo_mode, i_parity_enable, i_tx_hold_write, i_tx_hold_to_shift} = 6'h00;
      {i_tx_shift_busy, i_hold_empty_irq_en, i_line_irq_en, i_nrst, i_addr} = 7'h00;
      {i_parity_even_select, i_word_len_sel, i_tx_queue_empty} = 4'hF;
      r = $urandom(32'h3047);
      repeat (10) @(posedge i_clock);
      i_nrst <= 1'b1;
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(3'h3, 8'hFF);
      @(posedge i_clock);
      {i_addr, i_wr} <= {LINE_STATUS_OFS, 1'b1};
      @(posedge i_clock);
      i_wr <= 1'b0;
      rd(LINE_STATUS_OFS, 8'hFF);
      tx_seq();
      // every word length; the short two without parity, the long two with odd then even parity
      for (int w = 0; w < 4; w++) begin
         @(posedge i_clock);
         {i_word_len_sel, i_parity_even_select, i_parity_enable} <= {w[1:0], w[0], w[1]};
         ch($urandom, 0);
         rd(LINE_STATUS_OFS, 8'hFF);
         rd(RX_DATA_OFS, 8'hFF);
         rd(LINE_STATUS_OFS, 8'hFF);
      end
      // overrun with a parity error, then framing, then break
      @(posedge i_clock);
      i_line_irq_en <= 1'b1;
      ch($urandom, 0);
      ch($urandom, 1);
      `CHK(o_line_irq, 1'b1)
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      ch($urandom | 1, 2);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      brk_ch();
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      ch($urandom, 0);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      // fifo: errors ride with their characters; the fifth overruns a full queue
      @(posedge i_clock);
      i_fifo_mode <= 1'b1;
      tx_seq();
      ch($urandom, 0);
      ch($urandom, 1);
      ch($urandom | 1, 2);
      brk_ch();
      ch($urandom, 0);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(RX_DATA_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      rd(LINE_STATUS_OFS, 8'hFF);
      final_report();
   end
endmodule : slsl_line_status_tb
`default_nettype wire
